/* include/gpc_pkg.sv */
// Package for the pin twelve control and interrupt block
package gpc_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0]  PIN_TWELVE_CONTROL_OFS = 8'h3C;
	localparam logic [7:0]  IRQ_STATUS_OFS         = 8'h40;
	localparam logic [7:0]  IRQ_MASK_OFS           = 8'h44;
	localparam logic [7:0]  PIN_LEVEL_OFS          = 8'h48;
	// Field positions of the control register
	localparam int          IRQ_FWD_MASK_BIT  = 25;
	localparam int          TRIG_SEL_HI       = 23;
	localparam int          TRIG_SEL_LO       = 21;
	localparam int          IRQ_PEND_EN_BIT   = 20;
	localparam int          PAD_DRIVE_HI      = 14;
	localparam int          PAD_DRIVE_LO      = 12;
	localparam int          STRONG_PU_BIT     = 11;
	localparam int          PULLDOWN_BIT      = 9;
	localparam int          WEAK_PU_BIT       = 8;
	localparam int          IN_BUF_BIT        = 7;
	localparam int          OUT_DRV_BIT       = 6;
	localparam int          HYST_BIT          = 5;
	localparam int          ANALOG_SEL_BIT    = 4;
	localparam int          FUNC_SEL_HI       = 3;
	// Writable bits; the rest read zero
	localparam logic [31:0] CTRL_WRITE_MASK   = 32'h02F07BFF;
	// Reset value: drive level at top code
	localparam logic [31:0] CTRL_RESET        = 32'h00007000;
	// Status and mask layout
	localparam int          ST_TRIGGER_BIT    = 0;
	localparam int          ST_BADCODE_BIT    = 1;
	localparam logic [1:0]  STATUS_RESET      = 2'h0;
	localparam logic [1:0]  MASK_RESET        = 2'h0;

	// Trigger condition codes
	typedef enum logic [2:0] {
		TRIG_RISE  = 3'h0,
		TRIG_FALL  = 3'h1,
		TRIG_BOTH  = 3'h2,
		TRIG_HIGH  = 3'h3,
		TRIG_LOW   = 3'h4
	} gpc_trig_t;

	// Pin role codes
	typedef enum logic [3:0] {
		FN_FLASH_DATA_LINE_TWO = 4'h0,
		FN_PLAIN_PIN           = 4'h1,
		FN_SERIAL_PORT_TX      = 4'h2,
		FN_TWO_WIRE_DATA       = 4'h3,
		FN_SECOND_SPI_SELECT   = 4'h4,
		FN_PULSE_OUTPUT        = 4'h5,
		FN_AUDIO_RX_BIT_CLOCK  = 4'h6,
		FN_SERIAL_CTS          = 4'h7,
		FN_TIMER_CAPTURE       = 4'h8
	} gpc_func_t;

	// Pad settings carried together
	typedef struct packed {
		logic [2:0] pad_drive_level;
		logic       strong_pullup_on;
		logic       pulldown_on;
		logic       weak_pullup_on;
		logic       input_buffer_on;
		logic       output_driver_on;
		logic       hysteresis_input_on;
		logic       analog_on;
	} gpc_pad_t;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} gpc_req_t;
endpackage

/* rtl/gpc_pin_ctrl.sv */
// Pin twelve control register, trigger detection and interrupt forwarding
`timescale 1ns/100ps
module gpc_pin_ctrl
	import gpc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        clk_en_i,
	// Register port
	input  wire gpc_req_t    req_i,
	output logic [31:0]      rdata_o,
	// Pad level from outside
	input  wire logic        pad_level_i,
	// Pad and function controls
	output gpc_pad_t         pad_o,
	output gpc_func_t        func_o,
	output logic             func_valid_o,
	// Interrupt towards the chip interrupt controller
	output logic             chip_irq_o,
	// Local level interrupt from status and mask
	output logic             irq_o
);

	// Register map, byte offsets on the local port
	//   0x3C  pin twelve control, read and write
	//   0x40  event status, sticky, read clears it
	//   0x44  event mask, bits 1:0, read and write
	//   0x48  pin level view, read only
	//   Other offsets read zero, writes dropped

	// Control register fields, high bit first
	//   31:26  reserved, read zero
	//   25     irq_forward_mask, pass requests on
	//   24     reserved, read zero
	//   23:21  trigger_condition_select
	//   20     irq_pending_enable
	//   19:15  reserved, read zero
	//   14:12  pad_drive_level, resets to top code
	//   11     strong_pullup_on
	//   10     reserved, read zero
	//   9      pulldown_on
	//   8      weak_pullup_on
	//   7      input_buffer_on
	//   6      output_driver_on
	//   5      hysteresis_input_on
	//   4      analog select, converter channel
	//   3:0    pin_function_select

	// Trigger condition codes
	//   000  rising edge of the pad level
	//   001  falling edge of the pad level
	//   010  either edge
	//   011  high level, every cycle it holds
	//   100  low level, every cycle it holds
	//   Others reserved, never trigger

	// Pin role codes on func_o
	//   0x0  flash_data_line_two
	//   0x1  plain general-purpose pin
	//   0x2  serial_port_transmit
	//   0x3  two_wire_data_line
	//   0x4  second_spi_select
	//   0x5  pulse_output_channel
	//   0x6  audio_receive_bit_clock
	//   0x7  serial_clear_to_send
	//   0x8  timer_capture_input
	//   Others reserved, func_valid_o low

	// Drive level codes on pad_drive_level
	//   000  weakest of eight steps
	//   111  strongest, the reset choice
	//   Steps in between rise evenly

	// Status and mask layout, same bits
	//   bit 0  trigger seen while enabled
	//   bit 1  reserved code written to control
	//   A read of status clears both bits
	//   An event in the read cycle still sets

	// Pin level view layout
	//   bit 0  synchronised pad level
	//   bit 1  pending flag

	// Latency from a pad change
	//   edge k    pad level moves
	//   edge k+1  first stage holds it
	//   edge k+2  second stage holds it
	//   edge k+3  pending, status, request rise
	//   edge k+4  local level interrupt rises
	//   Read data stand one cycle after the strobe
	//   Pad and role outputs lag the register by one

	// Pending flag behaviour
	//   Enable low clears it at once
	//   A trigger sets it, beating a status read
	//   A status read clears it otherwise
	//   Request leaves only with mask bit set

	// Clock enable
	//   Low freezes every flop, strobes lost
	//   Pad history freezes too, so an edge
	//   that spans a frozen stretch shows late

	// Hazards and limits
	//   Level modes re-set pending each cycle,
	//   so a status read only clears it once
	//   the pad lets go of the level.
	//   Pulses under one clock may be lost
	//   in the synchroniser.
	//   Pad settings change one cycle after
	//   the register, all in the same edge.
	//   Only one pin may own the converter
	//   channel; nothing here can enforce it.
	//   A reserved trigger code disarms the
	//   detector instead of guessing a mode.
	//   Reset sets the drive level to its top
	//   code and every other field to zero.


	// Control register and status
	logic [31:0] ctrl_q;         // Control register
	logic [31:0] ctrl_d;         // Its next value
	logic        sync1_q;        // First synchroniser stage
	logic        sync2_q;        // Second synchroniser stage
	logic        prev_q;         // Previous synchronised level
	logic        pending_q;      // Trigger pending flag
	logic [1:0]  status_q;       // Sticky event status
	logic [1:0]  mask_q;         // Interrupt mask
	logic        trig_hit;       // Trigger condition met this cycle
	logic        wr_ctrl;        // Write to control register
	logic        rd_ctrl;        // Read of control register
	logic        rd_status;      // Read of status register
	logic        bad_code;       // Reserved code written
	gpc_trig_t   trig_sel;       // Current trigger selection
	logic        edge_rise;      // Synchronised level rose
	logic        edge_fall;      // Synchronised level fell
	logic        new_event;      // Trigger while enabled
	logic        wr_mask;        // Write to mask register
	logic        rd_mask;        // Read of mask register
	logic        rd_level;       // Read of pin level view

	// Decode of a register address against an offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// Trigger codes above low level are reserved
	function automatic logic trig_legal(input logic [2:0] c);
		trig_legal = (c <= TRIG_LOW);
	endfunction

	// Role codes above timer capture are reserved
	function automatic logic func_legal(input logic [3:0] c);
		func_legal = (c <= FN_TIMER_CAPTURE);
	endfunction

	// Strobe decodes
	assign wr_ctrl   = req_i.wr && hit(req_i.addr, PIN_TWELVE_CONTROL_OFS);
	assign rd_ctrl   = req_i.rd && hit(req_i.addr, PIN_TWELVE_CONTROL_OFS);
	assign rd_status = req_i.rd && hit(req_i.addr, IRQ_STATUS_OFS);
	assign trig_sel  = gpc_trig_t'(ctrl_q[TRIG_SEL_HI:TRIG_SEL_LO]);
	assign wr_mask   = req_i.wr && hit(req_i.addr, IRQ_MASK_OFS);
	assign rd_mask   = req_i.rd && hit(req_i.addr, IRQ_MASK_OFS);
	assign rd_level  = req_i.rd && hit(req_i.addr, PIN_LEVEL_OFS);

	// Edges of the synchronised pad level
	assign edge_rise = sync2_q && !prev_q;
	assign edge_fall = !sync2_q && prev_q;

	// Trigger that counts, enable bit set
	assign new_event = ctrl_q[IRQ_PEND_EN_BIT] && trig_hit;

	// Reserved bits masked off on write
	assign ctrl_d = req_i.wdata & CTRL_WRITE_MASK;

	// Write of a reserved trigger or role code
	assign bad_code = wr_ctrl &&
		(!trig_legal(req_i.wdata[TRIG_SEL_HI:TRIG_SEL_LO]) ||
		 !func_legal(req_i.wdata[FUNC_SEL_HI:0]));

	// Control register storage
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= CTRL_RESET;
		end else if (clk_en_i && wr_ctrl) begin
			ctrl_q <= ctrl_d;
		end
	end

	// Pad level synchroniser and history
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else if (clk_en_i) begin
			sync1_q <= pad_level_i;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Trigger condition selection
	always_comb begin
		trig_hit = 1'b0;
		unique case (trig_sel)
			// Rising edge
			TRIG_RISE: begin
				trig_hit = edge_rise;
			end
			// Falling edge
			TRIG_FALL: begin
				trig_hit = edge_fall;
			end
			// Either edge
			TRIG_BOTH: begin
				trig_hit = edge_rise || edge_fall;
			end
			// High level
			TRIG_HIGH: begin
				trig_hit = sync2_q;
			end
			// Low level
			TRIG_LOW: begin
				trig_hit = !sync2_q;
			end
			// Reserved codes never trigger
			default:   trig_hit = 1'b0;
		endcase
	end

	// Pending flag: set wins over the clear by status read
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending_q <= 1'b0;
		end else if (clk_en_i) begin
			if (!ctrl_q[IRQ_PEND_EN_BIT]) begin
				pending_q <= 1'b0;
			end else if (trig_hit) begin
				pending_q <= 1'b1;
			end else if (rd_status) begin
				pending_q <= 1'b0;
			end
		end
	end

	// Forward to the chip interrupt controller
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chip_irq_o <= 1'b0;
		end else if (clk_en_i) begin
			chip_irq_o <= ctrl_q[IRQ_PEND_EN_BIT] &&
				ctrl_q[IRQ_FWD_MASK_BIT] &&
				(pending_q || trig_hit);
		end
	end

	// Sticky status, cleared by reading it; a new event wins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_q <= STATUS_RESET;
		end else if (clk_en_i) begin
			status_q <= (rd_status ? 2'h0 : status_q) |
				{bad_code,
				 new_event};
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mask_q <= MASK_RESET;
		end else if (clk_en_i && wr_mask) begin
			mask_q <= req_i.wdata[1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			irq_o <= |(status_q & mask_q);
		end
	end

	// Read data, one cycle after the read strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 32'h0;
		end else if (clk_en_i) begin
			rdata_o <= 32'h0;
			if (rd_ctrl) begin
				rdata_o <= ctrl_q;
			end else if (rd_status) begin
				rdata_o <= {30'h0, status_q};
			end else if (rd_mask) begin
				rdata_o <= {30'h0, mask_q};
			end else if (rd_level) begin
				rdata_o <= {30'h0, pending_q, sync2_q};
			end
		end
	end

	// Pad control outputs from the register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pad_o <= '0;
			pad_o.pad_drive_level <= CTRL_RESET[PAD_DRIVE_HI:PAD_DRIVE_LO];
		end else if (clk_en_i) begin
			pad_o.pad_drive_level <=
				ctrl_q[PAD_DRIVE_HI:PAD_DRIVE_LO];
			pad_o.strong_pullup_on    <= ctrl_q[STRONG_PU_BIT];
			pad_o.weak_pullup_on      <= ctrl_q[WEAK_PU_BIT];
			pad_o.pulldown_on         <= ctrl_q[PULLDOWN_BIT];
			pad_o.input_buffer_on     <= ctrl_q[IN_BUF_BIT];
			pad_o.output_driver_on    <= ctrl_q[OUT_DRV_BIT];
			pad_o.hysteresis_input_on <= ctrl_q[HYST_BIT];
			pad_o.analog_on           <= ctrl_q[ANALOG_SEL_BIT];
		end
	end

	// Role select; analog mode or reserved code gives no digital role
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			func_o       <= FN_FLASH_DATA_LINE_TWO;
			func_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			func_o       <= gpc_func_t'(ctrl_q[FUNC_SEL_HI:0]);
			func_valid_o <= !ctrl_q[ANALOG_SEL_BIT] &&
				func_legal(ctrl_q[FUNC_SEL_HI:0]);
		end
	end

endmodule

/* verification/gpc_pad_model.sv */
// Pad source model driving the pin level
`timescale 1ns/100ps
module gpc_pad_model (
	// Clock and wanted level
	input  wire logic clk_i,
	input  wire logic want_i,
	// Pad level
	output logic      pad_level_o
);
	// Start low, move well off the edge
	initial pad_level_o = 1'b0;
	always @(posedge clk_i) begin
		pad_level_o <= #37 want_i;
	end
endmodule

/* verification/gpc_chk.sv */
// Checker for the pin control block
`timescale 1ns/100ps
module gpc_chk
	import gpc_pkg::*;
(
	// Clock, reset, enable
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        clk_en_i,
	// Register port
	input wire gpc_req_t    req_i,
	input wire logic [31:0] rdata_o,
	// Pad side
	input wire logic        pad_level_i,
	input wire gpc_pad_t    pad_o,
	input wire gpc_func_t   func_o,
	input wire logic        func_valid_o,
	// Interrupts
	input wire logic        chip_irq_o,
	input wire logic        irq_o
);
	logic [31:0] sh_q; // Control shadow
	logic [31:0] p_q;  // Shadow one step older
	logic        up_q; // One enabled edge since reset
	wire         tk  = req_i.wr && req_i.addr == PIN_TWELVE_CONTROL_OFS;
	wire [2:0]   md  = sh_q[23:21];
	wire         arm = sh_q[25] && sh_q[20] && clk_en_i;
	// Follow accepted control writes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sh_q <= CTRL_RESET;
			p_q  <= CTRL_RESET;
			up_q <= 1'b0;
		end else if (clk_en_i) begin
			p_q  <= sh_q;
			up_q <= 1'b1;
			if (tk) begin
				sh_q <= req_i.wdata & CTRL_WRITE_MASK;
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_rise;
		arm && md == 3'h0 && $rose(pad_level_i);
	endsequence
	sequence s_both;
		arm && md == 3'h2 && $changed(pad_level_i);
	endsequence
	sequence s_low;
		(arm && md == 3'h4 && !pad_level_i) [*6];
	endsequence
	property p_mask; !sh_q[25] && !p_q[25] |-> !chip_irq_o; endproperty
	a_mask: assert property (p_mask) else $error("irq unmasked");
	property p_en; !sh_q[20] && !p_q[20] |-> !chip_irq_o; endproperty
	a_en: assert property (p_en) else $error("irq disabled");
	property p_pad; pad_o == {p_q[14:11], p_q[9:4]}; endproperty
	a_pad: assert property (p_pad) else $error("pad");
	property p_func;
		func_o == p_q[3:0] &&
			func_valid_o == (up_q && !p_q[4] && p_q[3:0] <= 4'h8);
	endproperty
	a_func: assert property (p_func) else $error("func");
	property p_read;
		clk_en_i && req_i.rd && req_i.addr == PIN_TWELVE_CONTROL_OFS
			|=> rdata_o == p_q;
	endproperty
	a_read: assert property (p_read) else $error("read");
	property p_rise; s_rise |-> ##[1:5] chip_irq_o; endproperty
	a_rise: assert property (p_rise) else $error("rise");
	property p_both; s_both |-> ##[1:5] chip_irq_o; endproperty
	a_both: assert property (p_both) else $error("both");
	property p_low; s_low |-> chip_irq_o; endproperty
	a_low: assert property (p_low) else $error("low");
endmodule
bind gpc_pin_ctrl gpc_chk u_chk (.clk_i, .rst_b_i, .clk_en_i, .req_i,
	.rdata_o, .pad_level_i, .pad_o, .func_o, .func_valid_o, .chip_irq_o,
	.irq_o);

/* verification/gpio_pin_control_interrupt_test.sv */
// Self-checking bench for the pin control block
`timescale 1ns/100ps
module gpio_pin_control_interrupt_test
	import gpc_pkg::*;
;
	logic        clk = 0, rst_b = 0, en = 1, want = 0, st = 0;
	logic        lvl, fv, cirq, irq;
	logic [31:0] rdata, d, q[$];
	gpc_req_t    req = '0;
	gpc_pad_t    pad;
	gpc_func_t   fn;
	int          err_count = 0, comparisons = 0;
	// Design and pad source
	gpc_pin_ctrl uut (.clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
		.req_i(req), .rdata_o(rdata), .pad_level_i(lvl), .pad_o(pad),
		.func_o(fn), .func_valid_o(fv), .chip_irq_o(cirq), .irq_o(irq));
	gpc_pad_model pm (.clk_i(clk), .want_i(want), .pad_level_o(lvl));
	initial forever #50 clk = ~clk;
	// Compare and count
	task automatic chk(input logic [31:0] s, e, input string n);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One-cycle register write
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	// Read; expected data queued
	task rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
	endtask
	// Read data checked the cycle after a taken read
	always @(posedge clk) begin
		st <= req.rd && en;
		if (st)
			chk(rdata, q.pop_front(), "rdata");
	end
	// Hang guard
	initial begin
		#400000;
		err_count++;
		end_sim();
	end
	initial begin
		void'($urandom(80));
		w(2);
		rst_b <= 1'b1;
		rd(PIN_TWELVE_CONTROL_OFS, CTRL_RESET);
		rd(8'h90, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = $urandom & 32'hFDEFFFFF;
			wr(PIN_TWELVE_CONTROL_OFS, d);
			rd(PIN_TWELVE_CONTROL_OFS, d & CTRL_WRITE_MASK);
			chk(pad, {d[14:11], d[9:4]}, "pad");
			chk(fn, d[3:0], "func");
			chk(fv, !d[4] && d[3:0] < 9, "valid");
		end
		// Writes ignored while clock enable is low
		en <= 1'b0;
		wr(PIN_TWELVE_CONTROL_OFS, 32'h0);
		en <= 1'b1;
		rd(PIN_TWELVE_CONTROL_OFS, d & CTRL_WRITE_MASK);
		// Every legal trigger code, then reserved code 5 last
		for (int c = 0; c < 6; c++) begin
			d = 32'h02107000 | (c << 21);
			wr(PIN_TWELVE_CONTROL_OFS, d & 32'hFFEFFFFF);
			want <= (c == 1 || c == 4);
			w(6);
			wr(PIN_TWELVE_CONTROL_OFS, d);
			w(2);
			chk(cirq, 0, "quiet");
			want <= !want;
			w(7);
			chk(cirq, c < 5, "fire");
			wr(PIN_TWELVE_CONTROL_OFS, d & 32'hFDFFFFFF);
			w(2);
			chk(cirq, 0, "masked");
		end
		// Status, mask and local interrupt
		rd(IRQ_STATUS_OFS, 32'h3);
		wr(IRQ_MASK_OFS, 32'h1);
		wr(PIN_TWELVE_CONTROL_OFS, 32'h00307000);
		want <= 1'b0;
		w(7);
		chk(irq, 1, "irq");
		wr(IRQ_MASK_OFS, 32'h0);
		w(2);
		chk(irq, 0, "irq masked");
		rd(IRQ_MASK_OFS, 32'h0);
		rd(IRQ_STATUS_OFS, 32'h1);
		wr(IRQ_MASK_OFS, 32'h1);
		w(2);
		chk(irq, 0, "irq cleared");
		w(3);
		end_sim();
	end
endmodule
